//--- core/oprs_regs.sv
// What this block does
// - Routing bit set sends right DAC path one into right line output.
// - Seven-bit path volume code, read/write, resets to zero.
// - Upper four bits select right line output level 0 to 9 dB.
// - Mute bit zero keeps output muted; one unmutes; resets zero.
// - Read-only settling flag is one while gains still being applied.
// - Lowest bit powers right line output fully; resets zero.
// - Power status shows DACs, line outputs, headphone drivers powered.
// - Short status shows live short on four headphone drivers.
// - Short status next two bits show common drivers powered up.
// - Sticky flags latch shorts on four headphone drivers.
// - Sticky button-press flag set on headset button press.
// - Sticky headset flag set on insertion or removal.
// - Two lowest flags show ADC power below AGC noise threshold.
`timescale 1ns/1ps
`include "oprs_consts.svh"
module oprs_regs (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              clk_en,
	// register port
	input  wire logic [7:0]        reg_addr,
	input  wire oprs_pkg::oprs_byte_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output oprs_pkg::oprs_byte_t   reg_rdata,
	output logic                   reg_hit,
	// analog control
	output logic                   route_dac_path_one,
	output oprs_pkg::oprs_vol_t    path_volume,
	output oprs_pkg::oprs_lvl_t    line_level,
	output logic                   line_unmute,
	output logic                   line_power_on,
	// analog status
	input  wire logic              gain_pending,
	input  wire logic [6:0]        module_powered,
	input  wire logic [3:0]        driver_short,
	input  wire logic [1:0]        common_powered,
	input  wire logic              button_press,
	input  wire logic              headset_change,
	input  wire logic [1:0]        agc_below_noise
);
	import oprs_pkg::*;

	oprs_byte_t dac_vol;
	oprs_byte_t level_ctrl;
	oprs_byte_t sticky_flags;
	oprs_byte_t next_rdata;
	logic       sticky_clear;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction : addr_is

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			dac_vol <= `OPRS_RST_BYTE;
		else if (clk_en && reg_wr && addr_is(reg_addr, `OPRS_ADDR_DAC_VOL))
			dac_vol <= reg_wdata;
	end

	// reserved bit and status bit are not stored
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			level_ctrl <= `OPRS_RST_BYTE;
		else if (clk_en && reg_wr && addr_is(reg_addr, `OPRS_ADDR_LEVEL))
		begin
			level_ctrl <= reg_wdata;
			level_ctrl[`OPRS_BIT_RSVD]   <= 1'b0;
			level_ctrl[`OPRS_BIT_SETTLE] <= 1'b0;
		end
	end

	assign route_dac_path_one = dac_vol[`OPRS_BIT_ROUTE];
	assign path_volume        = dac_vol[6:0];
	// out-of-range codes clamp to the 9 dB maximum
	assign line_level    = (level_ctrl[7:4] > `OPRS_LVL_MAX) ?
		`OPRS_LVL_MAX : level_ctrl[7:4];
	assign line_unmute   = level_ctrl[`OPRS_BIT_MUTE];
	assign line_power_on = level_ctrl[`OPRS_BIT_POWER];

	// reading the flag register clears it
	assign sticky_clear = reg_rd && addr_is(reg_addr, `OPRS_ADDR_STICKY);

	oprs_sticky #(
		.WIDTH (8)
	) u_sticky (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.event_in ({driver_short, button_press, headset_change,
			agc_below_noise}),
		.clear    (sticky_clear),
		.flags    (sticky_flags)
	);

	always_comb
	begin
		next_rdata = `OPRS_RST_BYTE;
		reg_hit    = 1'b1;
		case (reg_addr)
			`OPRS_ADDR_DAC_VOL:
				next_rdata = dac_vol;
			`OPRS_ADDR_LEVEL:
				next_rdata = {level_ctrl[7:2], gain_pending,
					level_ctrl[0]};
			`OPRS_ADDR_PWR:
				next_rdata = {module_powered, 1'b0};
			`OPRS_ADDR_SHORT:
				next_rdata = {driver_short, common_powered,
					2'b00};
			`OPRS_ADDR_STICKY:
				next_rdata = sticky_flags;
			default:
				reg_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= `OPRS_RST_BYTE;
		else if (clk_en && reg_rd)
			reg_rdata <= next_rdata;
	end
endmodule : oprs_regs

//--- core/oprs_consts.svh
`ifndef OPRS_CONSTS_SVH
`define OPRS_CONSTS_SVH
`define OPRS_ADDR_DAC_VOL    8'h5C
`define OPRS_ADDR_LEVEL      8'h5D
`define OPRS_ADDR_PWR        8'h5E
`define OPRS_ADDR_SHORT      8'h5F
`define OPRS_ADDR_STICKY     8'h60
`define OPRS_RST_BYTE        8'h00
`define OPRS_LVL_MAX         4'h9
`define OPRS_BIT_ROUTE       7
`define OPRS_BIT_MUTE        3
`define OPRS_BIT_RSVD        2
`define OPRS_BIT_SETTLE      1
`define OPRS_BIT_POWER       0
`endif

//--- core/oprs_pkg.sv
package oprs_pkg;
	typedef logic [7:0] oprs_byte_t;
	typedef logic [6:0] oprs_vol_t;
	typedef logic [3:0] oprs_lvl_t;
endpackage : oprs_pkg

//--- core/oprs_sticky.sv
`timescale 1ns/1ps
module oprs_sticky #(
	parameter int WIDTH = 8
)(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// events and clear
	input  wire logic [WIDTH-1:0] event_in,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] flags
);
	initial
	begin
		if (WIDTH < 1)
			$error("oprs_sticky: WIDTH must be at least 1");
	end

	// set wins over clear so a same-cycle event survives
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			flags <= '0;
		else if (clk_en)
			flags <= (clear ? '0 : flags) | event_in;
	end
endmodule : oprs_sticky

//--- bench/oprs_regs_sva.sv
`timescale 1ns/1ps
module oprs_regs_sva
	import oprs_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire oprs_byte_t reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire oprs_byte_t reg_rdata,
	input wire logic       route_dac_path_one,
	input wire oprs_vol_t  path_volume,
	input wire oprs_lvl_t  line_level,
	input wire logic       line_unmute,
	input wire logic       line_power_on,
	input wire logic       gain_pending,
	input wire logic [6:0] module_powered,
	input wire logic       reg_hit,
	input wire logic [3:0] driver_short,
	input wire logic [1:0] common_powered
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire wv = reg_wr & clk_en & (reg_addr == 8'h5C);
	wire wl = reg_wr & clk_en & (reg_addr == 8'h5D);
	wire rl = reg_rd & clk_en & (reg_addr == 8'h5D);
	AST_VOL: assert property (
		wv |=> {route_dac_path_one, path_volume} == $past(reg_wdata))
		else $error("path byte");
	AST_HOLD: assert property (
		!wv |=> $stable(path_volume)) else $error("volume moved");
	AST_LEVEL: assert property (
		wl && reg_wdata[7:4] <= 4'h9 |=> line_level == $past(reg_wdata[7:4]))
		else $error("level");
	AST_MUTE: assert property (
		wl |=> line_unmute == $past(reg_wdata[3])) else $error("mute");
	AST_POWER: assert property (
		wl |=> line_power_on == $past(reg_wdata[0])) else $error("power");
	AST_RSVD: assert property (
		rl |=> !reg_rdata[2]) else $error("reserved bit");
	AST_SETTLE: assert property (
		rl |=> reg_rdata[1] == $past(gain_pending)) else $error("settle");
	AST_PSTAT: assert property (
		reg_rd && clk_en && reg_addr == 8'h5E
		|=> reg_rdata == {$past(module_powered), 1'b0}) else $error("pstat");
	AST_SHORT: assert property (
		reg_rd && clk_en && reg_addr == 8'h5F
		|=> reg_rdata == {$past(driver_short), $past(common_powered), 2'b00})
		else $error("short status");
	AST_HIT: assert property (
		reg_hit == (reg_addr >= 8'h5C && reg_addr <= 8'h60))
		else $error("hit decode");
	AST_FREEZE: assert property (
		!clk_en |=> $stable(reg_rdata) && $stable(path_volume)
		&& $stable(line_power_on)) else $error("frozen state moved");
endmodule : oprs_regs_sva
bind oprs_regs oprs_regs_sva i_sva (.clk_sys, .sys_rst, .clk_en, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .route_dac_path_one,
	.path_volume, .line_level, .line_unmute, .line_power_on,
	.gain_pending, .module_powered, .reg_hit, .driver_short,
	.common_powered);

//--- bench/output_power_status_regs_tb_top.sv
`timescale 1ns/1ps
module output_power_status_regs_tb_top;
	import oprs_pkg::*;
	logic clk_sys = 0, sys_rst = 1, wr = 0, rd = 0, gp = 0, bp = 0, hc = 0;
	logic [7:0] ad = 0, wd = 0;
	logic [6:0] mp = 0;
	logic [3:0] ds = 0;
	logic [1:0] cp = 0, ag = 0;
	oprs_byte_t rdat;
	logic rt, mu, po, hit;
	logic ce = 1;
	oprs_vol_t vol;
	oprs_lvl_t lvl;
	int bad_count = 0, checked = 0;
	always #4 clk_sys = ~clk_sys;
	oprs_regs i_oprs_regs (.clk_sys, .sys_rst, .clk_en(ce), .reg_addr(ad),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
		.reg_hit(hit), .route_dac_path_one(rt), .path_volume(vol),
		.line_level(lvl), .line_unmute(mu), .line_power_on(po),
		.gain_pending(gp), .module_powered(mp), .driver_short(ds),
		.common_powered(cp), .button_press(bp), .headset_change(hc),
		.agc_below_noise(ag));
	task automatic chk(input logic [7:0] g, e);
		checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
			bad_count++;
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, d);
		@(negedge clk_sys) {ad, wd, wr} = {a, d, 1'b1};
		@(negedge clk_sys) wr = 0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, e);
		@(negedge clk_sys) {ad, rd} = {a, 1'b1};
		@(negedge clk_sys) rd = 0;
		chk(rdat, e);
	endtask : rreg
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#20000;
		bad_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (3) @(negedge clk_sys);
		sys_rst = 0;
		for (int a = 'h5C; a <= 'h60; a++) rreg(8'(a), 8'h00);
		rreg(8'h10, 8'h00);
		chk({7'h00, hit}, 8'h00);
		$display("reset test done");
		wreg(8'h5C, 8'hAB);
		rreg(8'h5C, 8'hAB);
		chk({7'h00, hit}, 8'h01);
		chk({rt, vol}, 8'hAB);
		ce = 0;
		wreg(8'h5C, 8'h12);
		ce = 1;
		rreg(8'h5C, 8'hAB);
		$display("path test done");
		gp = 1;
		wreg(8'h5D, 8'h99);
		rreg(8'h5D, 8'h9B);
		chk({lvl, mu, po, 2'b00}, 8'h9C);
		gp = 0;
		rreg(8'h5D, 8'h99);
		$display("level test done");
		mp = 7'h55;
		wreg(8'h5E, 8'hFE);
		rreg(8'h5E, 8'hAA);
		{ds, cp} = 6'h29;
		rreg(8'h5F, 8'hA4);
		$display("status test done");
		{ds, cp} = 0;
		rreg(8'h60, 8'hA0);
		@(negedge clk_sys) {ds, bp, hc, ag} = 8'h5F;
		@(negedge clk_sys) {ds, bp, hc, ag} = 0;
		rreg(8'h60, 8'h5F);
		rreg(8'h60, 8'h00);
		@(negedge clk_sys) {ad, rd, bp} = {8'h60, 1'b1, 1'b1};
		@(negedge clk_sys) {rd, bp} = 2'b00;
		chk(rdat, 8'h00);
		rreg(8'h60, 8'h08);
		$display("sticky test done");
		report_and_stop;
	end
endmodule : output_power_status_regs_tb_top
